// ===== hsq_sched.sv
// Egress scheduler: strict priority over deficit weighted round robin, eight classes.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`default_nettype none

// Functional notes
// - Classes 0 to 7, higher number wins.
// - Serve top strict queue until it empties.
// - Higher strict level outranks lower level.
// - Top N classes strict, rest weighted; N 0-6,8.
// - Class 7 gets level N; weighted index c+1 (code indexes weight and ptr by class c).
// - Weighted arbitration only when strict queues empty.
// - Weighted service skips empty queues.
// - Visit weighted queues high to low, wrap.
// - Carry overrun as negative deficit to later rounds.
// - Bandwidth share proportional to configured weight.
// - Equal-priority queues of a class share fairly.
// - One weight per class, eight in all.
// - Multicast class c maps to unicast c.
// - Multicast queues scheduled alongside their unicast class.
module hsq_sched (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire hsq_pkg::hsq_avm_req_t avs_req,
	output hsq_pkg::hsq_avm_rsp_t avs_rsp,
	// Queue side
	input wire hsq_pkg::hsq_qstat_t q_stat,
	output hsq_pkg::hsq_deq_t deq,
	// Transmit side
	output hsq_pkg::hsq_grant_t tx_data,
	output logic tx_valid,
	input wire logic tx_ready
);
	import hsq_pkg::*;

	// ----------------------------------------------------------------
	// State and derived class vectors
	// ----------------------------------------------------------------
	hsq_sched_st_t st_reg;
	hsq_sched_st_t st_next;
	logic [NTC-1:0] sp_mask;
	logic [NTC-1:0] cls_ne;
	logic [NTC-1:0] sp_ne;
	logic [NTC-1:0] mc_sel;
	logic [NTC-1:0][LEN_W-1:0] head_len;
	logic sp_found;
	logic [2:0] sp_tc;
	logic fifo_ready;
	logic push;
	hsq_grant_t push_data;
	logic [DEF_W-1:0] quantum;
	logic signed [DEF_W-1:0] def_avail;
	logic wrr_ok;
	logic [31:0] rd_val;

	assign avs_rsp = st_reg.rsp;
	assign deq = st_reg.deq;

	// A multicast queue of class c stands beside the unicast queue of class c.
	for (genvar c = 0; c < NTC; c++) begin : g_cls
		assign sp_mask[c] = (4'(c) + st_reg.sp_cnt) >= SP_CNT_ALL;
		assign cls_ne[c] = q_stat.uc_ne[c] | q_stat.mc_ne[c];
		assign sp_ne[c] = cls_ne[c] & sp_mask[c];
		assign mc_sel[c] = q_stat.mc_ne[c] & (!q_stat.uc_ne[c] | st_reg.mc_turn[c]);
		assign head_len[c] = mc_sel[c] ? q_stat.mc_len[c] : q_stat.uc_len[c];
	end

	// Highest class number wins among strict queues that hold frames.
	hsq_pick u_sp_pick (
		.req(sp_ne),
		.found(sp_found),
		.idx(sp_tc)
	);

	assign quantum = 16'(st_reg.weight[st_reg.ptr]) * QUANT_BYTES;
	assign wrr_ok = cls_ne[st_reg.ptr] & ~sp_mask[st_reg.ptr];
	assign def_avail = st_reg.credited ? $signed(st_reg.deficit[st_reg.ptr]) :
		$signed(st_reg.deficit[st_reg.ptr]) + $signed(quantum);

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		if (avs_req.address[7:5] == WEIGHT_PAGE) begin
			rd_val[7:0] = st_reg.weight[avs_req.address[4:2]];
		end else if (avs_req.address[7:2] == ADDR_CTRL[7:2]) begin
			rd_val[3:0] = st_reg.sp_cnt;
		end else if (avs_req.address[7:2] == ADDR_STATUS[7:2]) begin
			rd_val[STAT_TC_LSB +: 3] = st_reg.last_tc;
			rd_val[STAT_MC_BIT] = st_reg.last_mc;
			rd_val[STAT_ROOM_BIT] = fifo_ready;
			rd_val[STAT_PTR_LSB +: 3] = st_reg.ptr;
			rd_val[STAT_CRED_BIT] = st_reg.credited;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic do_grant;
		logic [2:0] g_tc;
		do_grant = 1'b0;
		g_tc = 3'h0;
		st_next = st_reg;
		st_next.deq.valid = 1'b0;
		push = 1'b0;
		push_data = '0;

		// Every access waits exactly one cycle so read data can come from a flop.
		st_next.rsp.waitrequest = 1'b1;
		if ((avs_req.read | avs_req.write) & st_reg.rsp.waitrequest) begin
			st_next.rsp.waitrequest = 1'b0;
			st_next.rsp.readdata = rd_val;
		end
		if (avs_req.write & !st_reg.rsp.waitrequest) begin
			if (avs_req.address[7:5] == WEIGHT_PAGE) begin
				st_next.weight[avs_req.address[4:2]] = avs_req.writedata[7:0];
			end else if (avs_req.address[7:2] == ADDR_CTRL[7:2]) begin
				// A count of seven, or above eight, is not offered and is dropped.
				if (avs_req.writedata[3:0] <= SP_CNT_MAX ||
					avs_req.writedata[3:0] == SP_CNT_ALL) begin
					st_next.sp_cnt = avs_req.writedata[3:0];
				end
			end
		end

		unique case (st_reg.phase)
			HSQ_PICK: begin
				if (fifo_ready) begin
					if (sp_found) begin
						do_grant = 1'b1;
						g_tc = sp_tc;
					end else if (!wrr_ok) begin
						// Empty or strict class: move on, forgetting any credit.
						st_next.ptr = st_reg.ptr - 3'h1;
						st_next.credited = 1'b0;
						if (!cls_ne[st_reg.ptr]) begin
							st_next.deficit[st_reg.ptr] = '0;
						end
					end else if (def_avail > 0) begin
						do_grant = 1'b1;
						g_tc = st_reg.ptr;
						st_next.credited = 1'b1;
						st_next.deficit[st_reg.ptr] =
							DEF_W'(def_avail - $signed({2'b00, head_len[st_reg.ptr]}));
					end else begin
						// Allowance used up; keep the overrun for the next visit.
						st_next.deficit[st_reg.ptr] = def_avail;
						st_next.credited = 1'b0;
						st_next.ptr = st_reg.ptr - 3'h1;
					end
				end
			end
			HSQ_SETTLE: begin
				// Gives the queue a cycle to update its non-empty flag after a pop.
				st_next.phase = HSQ_PICK;
			end
		endcase

		if (do_grant) begin
			push = 1'b1;
			push_data.mc = mc_sel[g_tc];
			push_data.tc = g_tc;
			push_data.len = head_len[g_tc];
			st_next.deq.valid = 1'b1;
			st_next.deq.mc = mc_sel[g_tc];
			st_next.deq.tc = g_tc;
			st_next.mc_turn[g_tc] = ~mc_sel[g_tc];
			st_next.last_tc = g_tc;
			st_next.last_mc = mc_sel[g_tc];
			st_next.phase = HSQ_SETTLE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.phase <= HSQ_PICK;
			st_reg.rsp.waitrequest <= 1'b1;
			st_reg.sp_cnt <= SP_CNT_RST;
			st_reg.weight <= {NTC{WEIGHT_RST}};
			st_reg.ptr <= PTR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Grant buffer toward the transmit port
	// ----------------------------------------------------------------
	hsq_fifo #(
		.W($bits(hsq_grant_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	one_grant_a: assert property (@(posedge clk) disable iff (rst)
		deq.valid |=> !deq.valid)
		else $error("Two grants in consecutive cycles.");

	grant_push_a: assert property (@(posedge clk) disable iff (rst)
		push |=> deq.valid && deq.tc == $past(push_data.tc) && deq.mc == $past(push_data.mc))
		else $error("Dequeue pulse does not match buffered grant.");

	sp_first_a: assert property (@(posedge clk) disable iff (rst)
		deq.valid && !sp_mask[deq.tc] && $stable(st_reg.sp_cnt) |-> $past(sp_ne) == '0)
		else $error("Weighted grant while a strict queue held frames.");

	sp_top_a: assert property (@(posedge clk) disable iff (rst)
		push && sp_mask[push_data.tc] |-> (sp_ne >> push_data.tc) == 8'h01)
		else $error("Strict grant skipped a higher strict class.");

	no_empty_a: assert property (@(posedge clk) disable iff (rst)
		push |-> (push_data.mc ? q_stat.mc_ne[push_data.tc] : q_stat.uc_ne[push_data.tc]))
		else $error("Grant issued to an empty queue.");

	wrr_credit_a: assert property (@(posedge clk) disable iff (rst)
		push && !sp_mask[push_data.tc] |-> def_avail > 0 && push_data.tc == st_reg.ptr)
		else $error("Weighted grant without positive deficit.");

	ptr_down_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.ptr != $past(st_reg.ptr) |-> st_reg.ptr == $past(st_reg.ptr) - 3'h1)
		else $error("Round robin pointer did not step down by one.");

	mc_share_a: assert property (@(posedge clk) disable iff (rst)
		push && q_stat.uc_ne[push_data.tc] && q_stat.mc_ne[push_data.tc]
		|=> st_reg.mc_turn[$past(push_data.tc)] == !$past(push_data.mc))
		else $error("Unicast and multicast of a class did not alternate.");

	rst_state_a: assert property (@(posedge clk)
		$past(rst) |-> st_reg.ptr == PTR_RST && st_reg.deficit == '0 && !st_reg.credited)
		else $error("Scheduler state wrong after reset.");

	bus_ack_a: assert property (@(posedge clk) disable iff (rst)
		(avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest ##1
		avs_rsp.waitrequest)
		else $error("Bus access not answered in one wait cycle.");

	sp_count_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.sp_cnt <= SP_CNT_MAX || st_reg.sp_cnt == SP_CNT_ALL)
		else $error("Strict count holds a value not offered.");

	// ----------------------------------------------------------------
	// Further checks on grant pacing, pointer and configuration
	// ----------------------------------------------------------------
	strict_before_wrr_a: assert property (@(posedge clk) disable iff (rst)
		push && sp_ne != '0 |-> sp_mask[push_data.tc])
		else $error("Weighted grant while strict frames waited.");

	settle_phase_a: assert property (@(posedge clk) disable iff (rst)
		deq.valid |-> st_reg.phase == HSQ_SETTLE)
		else $error("Dequeue pulse outside the settle cycle.");

	pick_wait_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.phase == HSQ_SETTLE |-> !push)
		else $error("Grant made during the settle cycle.");

	full_stall_a: assert property (@(posedge clk) disable iff (rst)
		!fifo_ready |-> !push)
		else $error("Grant pushed into a full buffer.");

	visit_cred_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.ptr != $past(st_reg.ptr) |-> !st_reg.credited)
		else $error("Credit carried into the next class visit.");

	zero_weight_a: assert property (@(posedge clk) disable iff (rst)
		push && !sp_mask[push_data.tc] |-> st_reg.weight[push_data.tc] != 8'h00)
		else $error("Weighted grant to a class of weight zero.");

	strict_ptr_a: assert property (@(posedge clk) disable iff (rst)
		push && sp_mask[push_data.tc] |=> st_reg.ptr == $past(st_reg.ptr))
		else $error("Strict grant moved the round robin pointer.");

	ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.sp_cnt != $past(st_reg.sp_cnt) |-> $past(avs_req.write && !avs_rsp.waitrequest))
		else $error("Strict count changed without a bus write.");

	weight_write_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.weight != $past(st_reg.weight) |-> $past(avs_req.write && !avs_rsp.waitrequest))
		else $error("Weight changed without a bus write.");

	bus_idle_a: assert property (@(posedge clk) disable iff (rst)
		!(avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> avs_rsp.waitrequest)
		else $error("Bus answered with no access pending.");

endmodule : hsq_sched

`default_nettype wire

// ===== hsq_pkg.sv
// Shared types and constants of the hybrid strict-priority and weighted queue scheduler.
`default_nettype none

package hsq_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NTC = 8;
	localparam int unsigned LEN_W = 14;
	localparam int unsigned DEF_W = 16;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam logic [15:0] QUANT_BYTES = 16'h0040;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [2:0] WEIGHT_PAGE = 3'h1;
	localparam int unsigned STAT_TC_LSB = 0;
	localparam int unsigned STAT_MC_BIT = 3;
	localparam int unsigned STAT_ROOM_BIT = 4;
	localparam int unsigned STAT_PTR_LSB = 8;
	localparam int unsigned STAT_CRED_BIT = 11;

	// ----------------------------------------------------------------
	// Reset values and legal strict counts
	// ----------------------------------------------------------------
	localparam logic [3:0] SP_CNT_RST = 4'h0;
	localparam logic [3:0] SP_CNT_MAX = 4'h6;
	localparam logic [3:0] SP_CNT_ALL = 4'h8;
	localparam logic [7:0] WEIGHT_RST = 8'h0A;
	localparam logic [2:0] PTR_RST = 3'h7;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} hsq_avm_req_t;

	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} hsq_avm_rsp_t;

	typedef struct packed {
		logic [NTC-1:0] uc_ne;
		logic [NTC-1:0] mc_ne;
		logic [NTC-1:0][LEN_W-1:0] uc_len;
		logic [NTC-1:0][LEN_W-1:0] mc_len;
	} hsq_qstat_t;

	typedef struct packed {
		logic valid;
		logic mc;
		logic [2:0] tc;
	} hsq_deq_t;

	typedef struct packed {
		logic mc;
		logic [2:0] tc;
		logic [LEN_W-1:0] len;
	} hsq_grant_t;

	typedef enum logic {HSQ_PICK, HSQ_SETTLE} hsq_phase_t;

	typedef struct packed {
		hsq_phase_t phase;
		hsq_avm_rsp_t rsp;
		hsq_deq_t deq;
		logic [3:0] sp_cnt;
		logic [NTC-1:0][7:0] weight;
		logic [NTC-1:0][DEF_W-1:0] deficit;
		logic [2:0] ptr;
		logic credited;
		logic [NTC-1:0] mc_turn;
		logic [2:0] last_tc;
		logic last_mc;
	} hsq_sched_st_t;

endpackage : hsq_pkg

`default_nettype wire

// ===== hsq_pick.sv
// Finder of the highest set bit in a class request vector.
`default_nettype none

module hsq_pick (
	// Requests
	input wire logic [7:0] req,
	// Result
	output logic found,
	output logic [2:0] idx
);
	import hsq_pkg::*;

	always_comb begin
		found = 1'b0;
		idx = 3'h0;
		for (int i = 0; i < NTC; i++) begin
			if (req[i]) begin
				found = 1'b1;
				idx = 3'(i);
			end
		end
	end

endmodule : hsq_pick

`default_nettype wire

// ===== hsq_fifo.sv
// Grant buffer between the scheduler and the transmit port.
`default_nettype none

module hsq_fifo #(
	parameter int unsigned W = 18,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import hsq_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic room;
		logic nemp;
	} hsq_fifo_st_t;

	hsq_fifo_st_t st_reg;
	hsq_fifo_st_t st_next;
	logic push;
	logic pop;

	assign in_ready = st_reg.room;
	assign out_valid = st_reg.nemp;
	assign out_data = st_reg.mem[st_reg.rp];
	assign push = in_valid & st_reg.room;
	assign pop = st_reg.nemp & out_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (pop) begin
			st_next.rp = st_reg.rp + 1'b1;
		end
		st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		st_next.room = st_next.cnt != FULL;
		st_next.nemp = st_next.cnt != '0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.room <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	fifo_hold_a: assert property (@(posedge clk) disable iff (rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("Buffered grant changed before it was taken.");

	fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
		st_reg.cnt <= FULL && (st_reg.room == (st_reg.cnt != FULL)))
		else $error("Buffer level out of range or ready wrong.");

endmodule : hsq_fifo

`default_nettype wire

// ===== hsq_qmodel.sv
// Behavioural per-class frame queues that stand in front of the scheduler.
`default_nettype none
module hsq_qmodel (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Loading from the bench
	input wire logic load,
	input wire logic [7:0][7:0] uc_add,
	input wire logic [7:0][7:0] mc_add,
	input wire logic [13:0] len,
	// Scheduler side
	input wire hsq_pkg::hsq_deq_t deq,
	output hsq_pkg::hsq_qstat_t q_stat
);
	timeunit 1ns;
	timeprecision 1ps;
	import hsq_pkg::*;
	logic [7:0][7:0] uc_reg;
	logic [7:0][7:0] mc_reg;
	always_ff @(posedge clk) begin
		for (int c = 0; c < 8; c++) begin
			if (rst) begin
				uc_reg[c] <= 8'h00;
				mc_reg[c] <= 8'h00;
			end else begin
				uc_reg[c] <= uc_reg[c] + (load ? uc_add[c] : 8'h00)
					- ((deq.valid && !deq.mc && deq.tc == 3'(c)) ? 8'h01 : 8'h00);
				mc_reg[c] <= mc_reg[c] + (load ? mc_add[c] : 8'h00)
					- ((deq.valid && deq.mc && deq.tc == 3'(c)) ? 8'h01 : 8'h00);
			end
		end
	end
	// An empty queue shows no stale head length: the inverse is driven instead.
	always_comb begin
		for (int c = 0; c < 8; c++) begin
			q_stat.uc_ne[c] = (uc_reg[c] != 8'h00);
			q_stat.mc_ne[c] = (mc_reg[c] != 8'h00);
			q_stat.uc_len[c] = q_stat.uc_ne[c] ? len : ~len;
			q_stat.mc_len[c] = q_stat.mc_ne[c] ? len : ~len;
		end
	end
endmodule : hsq_qmodel
`default_nettype wire

// ===== tb.sv
// Self-checking bench of the egress scheduler with its queue model.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hsq_pkg::*;
	logic clk, rst, txv, txr, ld;
	hsq_avm_req_t req;
	hsq_avm_rsp_t rsp;
	hsq_qstat_t qs;
	hsq_deq_t deq;
	hsq_grant_t txd;
	hsq_grant_t gq[$];
	logic [7:0][7:0] uca, mca;
	logic [13:0] len;
	logic [31:0] q;
	int n_mismatch, checked, n_deq;
	hsq_sched uut (.clk(clk), .rst(rst), .avs_req(req), .avs_rsp(rsp), .q_stat(qs),
		.deq(deq), .tx_data(txd), .tx_valid(txv), .tx_ready(txr));
	hsq_qmodel qm (.clk(clk), .rst(rst), .load(ld), .uc_add(uca), .mc_add(mca), .len(len),
		.deq(deq), .q_stat(qs));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sampled mid-cycle so the values are those that the next rising edge sees.
	always @(negedge clk) begin
		if (txv === 1'b1 && txr === 1'b1) gq.push_back(txd);
		if (deq.valid === 1'b1) n_deq++;
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk_reg
	task automatic chk_gnt(input hsq_grant_t got, input hsq_grant_t exp);
		checked++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk_gnt
	function automatic hsq_grant_t g(input logic m, input logic [2:0] t);
		g = '{mc: m, tc: t, len: len};
	endfunction : g
	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		req <= '{read: !w, write: w, address: a, writedata: d};
		for (i = 0; i < 50; i++) begin
			@(negedge clk);
			if (rsp.waitrequest === 1'b0) break;
		end
		if (i == 50) n_mismatch++;
		q = rsp.readdata;
		@(posedge clk);
		req <= '0;
	endtask : bus
	task automatic rst_dut();
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		n_deq = 0;
	endtask : rst_dut
	task automatic ld_q(input logic [7:0][7:0] u, input logic [7:0][7:0] m);
		gq.delete();
		@(posedge clk);
		uca <= u;
		mca <= m;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
	endtask : ld_q
	task automatic wait_g(input int n);
		for (int i = 0; i < 3000 && gq.size() < n; i++) @(posedge clk);
		if (gq.size() < n) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, gq.size(), n);
			n_mismatch++;
		end
	endtask : wait_g
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk_reg(q, 32'(SP_CNT_RST));
		for (int c = 0; c < 8; c++) begin
			bus(1'b0, {WEIGHT_PAGE, 3'(c), 2'b00}, 32'h0000_0000);
			chk_reg(q, 32'(WEIGHT_RST));
		end
		bus(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk_reg(32'(q[STAT_ROOM_BIT]), 32'h0000_0001);
		bus(1'b1, 8'h40, 32'h0000_00FF);
		bus(1'b0, 8'h40, 32'h0000_0000);
		chk_reg(q, 32'h0000_0000);
	endtask : t_regs
	task automatic t_strict();
		logic [7:0][7:0] u;
		u = '0;
		u[7] = 8'h02;
		u[3] = 8'h01;
		u[1] = 8'h01;
		bus(1'b1, ADDR_CTRL, 32'(SP_CNT_ALL));
		ld_q(u, '0);
		wait_g(4);
		chk_gnt(gq[0], g(1'b0, 3'h7));
		chk_gnt(gq[1], g(1'b0, 3'h7));
		chk_gnt(gq[2], g(1'b0, 3'h3));
		chk_gnt(gq[3], g(1'b0, 3'h1));
	endtask : t_strict
	// Class 3 is the top weighted class under a strict count of four.
	task automatic t_hybrid();
		logic [7:0][7:0] u;
		u = '0;
		for (int c = 3; c < 7; c++) u[c] = 8'h01;
		bus(1'b1, ADDR_CTRL, 32'h0000_0004);
		bus(1'b1, ADDR_CTRL, 32'h0000_0007);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk_reg(q, 32'h0000_0004);
		ld_q(u, '0);
		wait_g(4);
		for (int i = 0; i < 4; i++) chk_gnt(gq[i], g(1'b0, 3'(6 - i)));
	endtask : t_hybrid
	task automatic t_mcast();
		logic [7:0][7:0] u, m;
		u = '0;
		m = '0;
		u[5] = 8'h02;
		m[5] = 8'h02;
		m[6] = 8'h01;
		bus(1'b1, ADDR_CTRL, 32'(SP_CNT_ALL));
		ld_q(u, m);
		wait_g(5);
		chk_gnt(gq[0], g(1'b1, 3'h6));
		for (int i = 1; i < 4; i++) begin
			chk_reg(32'(gq[i].tc), 32'h0000_0005);
			chk_reg(32'(gq[i].mc ^ gq[i + 1].mc), 32'h0000_0001);
		end
	endtask : t_mcast
	// Weights 3 and 1 with 96-byte frames: only a carried overrun gives 3:1.
	task automatic t_dwrr();
		logic [7:0][7:0] u;
		int n7;
		u = '0;
		u[7] = 8'h28;
		u[6] = 8'h28;
		n7 = 0;
		rst_dut();
		len <= 14'h0060;
		bus(1'b1, {WEIGHT_PAGE, 3'h7, 2'b00}, 32'h0000_0003);
		bus(1'b1, {WEIGHT_PAGE, 3'h6, 2'b00}, 32'h0000_0001);
		ld_q(u, '0);
		wait_g(24);
		for (int i = 0; i < 24; i++) n7 += (gq[i].tc === 3'h7);
		chk_reg(32'(n7 >= 17 && n7 <= 19), 32'h0000_0001);
		rst_dut();
		len <= 14'h0064;
	endtask : t_dwrr
	task automatic t_fill();
		logic [7:0][7:0] u;
		u = '0;
		u[7] = 8'h14;
		txr <= 1'b0;
		bus(1'b1, ADDR_CTRL, 32'(SP_CNT_ALL));
		ld_q(u, '0);
		repeat (100) @(posedge clk);
		chk_reg(32'(n_deq), 32'(FIFO_DEPTH));
		bus(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk_reg(32'(q[STAT_ROOM_BIT]), 32'h0000_0000);
		txr <= 1'b1;
		wait_g(20);
		chk_reg(32'(n_deq), 32'h0000_0014);
		chk_gnt(gq[19], g(1'b0, 3'h7));
	endtask : t_fill
	initial begin
		rst = 1'b1;
		req = '0;
		txr = 1'b1;
		ld = 1'b0;
		uca = '0;
		mca = '0;
		len = 14'h0064;
		n_mismatch = 0;
		checked = 0;
		n_deq = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_strict();
		t_hybrid();
		t_mcast();
		t_dwrr();
		t_fill();
		report_and_stop();
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
